// >>> hdl/cws_sequencer.sv
// control write sequencer: register slave, step execution, control register port
// assumes: avalon-mm master on ref_clk_i; control register bank reads combinationally
//
// Overview of operation
// - step width code at 14:12 gives field width as code plus one bits.
// - step start code at 11:8 puts the field lsb at bit 0 to 15.
// - step bits 7:0 name the control register written by the step.
// - second word bit 14 marks the last step; halt after it, else continue.
// - each step lasts 62.5 us times (2 to the power D plus 8) in total.
// - value bits above the chosen width are ignored.
// - writing one to cancel bit 9 stops the sequence at once.
// - writing one to go bit 8 starts at the first-slot field.
// - run consecutive steps until the last one, then clear go.
// - first slot 0-31 is ram, 32-48 fixed, 49-63 reserved.
// - status bits 9:4 show the slot of the step most recently loaded for execution.
// - status bit 0 is one while running, zero when idle.
// - control register writes from the bus are refused while running.
// - step word writes are copied into the slot named by the load field.
`default_nettype none

module cws_sequencer #(
  parameter int unsigned STEP_UNIT_X2_CYC = cws_pkg::STEP_UNIT_X2_CYC // two step units
) (
  input wire logic ref_clk_i, // 25 MHz clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [9:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  output logic [7:0] ctl_raddr_o, // control bank read address
  input wire logic [15:0] ctl_rdata_i, // control bank read data
  output logic ctl_we_o, // control bank write strobe
  output logic [7:0] ctl_waddr_o, // control bank write address
  output logic [15:0] ctl_wdata_o // control bank write data
);

  cws_store_if store_bus ();

  cws_pkg::cws_seq_t q;
  cws_pkg::cws_seq_t next_q;

  logic req;
  logic take;
  logic running;
  logic [7:0] idx;
  logic [15:0] view;
  logic [15:0] merged;
  logic [2:0] st_width;
  logic [3:0] st_start;
  logic [7:0] st_addr;
  logic st_last;
  logic [3:0] st_wait;
  logic [7:0] st_value;
  logic [15:0] width_mask;
  logic [15:0] field_mask;
  logic [15:0] field_bits;
  logic [31:0] step_total;
  logic [31:0] wait_load;

  ////////////////////////////////////////////////////////////////////////////
  // step store
  cws_step_store u_store (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bus(store_bus.store)
  );

  function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0] be);
    be_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and register view
  always_comb begin
    req = avs_read_i | avs_write_i;
    take = req & q.ack;
    idx = avs_address_i[9:2];
    running = (q.state != cws_pkg::S_IDLE);
    view = 16'h0000;
    case (idx)
      cws_pkg::IDX_LOAD: begin
        view[cws_pkg::LOAD_SLOT_LSB +: 5] = q.load_slot;
      end
      cws_pkg::IDX_TARGET: begin
        view = q.word_tgt;
      end
      cws_pkg::IDX_VALUE: begin
        view = q.word_val;
      end
      cws_pkg::IDX_LAUNCH: begin
        view[cws_pkg::LAUNCH_GO_BIT] = q.go;
        view[cws_pkg::LAUNCH_FIRST_LSB +: 6] = q.first_slot;
      end
      cws_pkg::IDX_STATUS: begin
        view[cws_pkg::STATUS_NOW_LSB +: 6] = q.now_slot;
        view[cws_pkg::STATUS_RUN_BIT] = running;
      end
      default: begin
        view = ctl_rdata_i;
      end
    endcase
    merged = be_merge(view, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // fields of the latched step and its field masks
  always_comb begin
    st_width = q.step[cws_pkg::TGT_WIDTH_LSB +: 3];
    st_start = q.step[cws_pkg::TGT_START_LSB +: 4];
    st_addr = q.step[cws_pkg::TGT_ADDR_LSB +: 8];
    st_last = q.step[cws_pkg::STEP_HI_BASE + cws_pkg::VAL_LAST_BIT];
    st_wait = q.step[cws_pkg::STEP_HI_BASE + cws_pkg::VAL_WAIT_LSB +: 4];
    st_value = q.step[cws_pkg::STEP_HI_BASE + cws_pkg::VAL_DATA_LSB +: 8];
    width_mask = (16'h0002 << st_width) - 16'h0001;
    // bits pushed past bit 15 by a high start position are simply lost
    field_mask = width_mask << st_start;
    field_bits = ({8'h00, st_value} & width_mask) << st_start;
    // total per step in cycles, half cycle rounded up
    step_total = (STEP_UNIT_X2_CYC * ((32'h0000_0001 << st_wait) + 32'h0000_0008) +
      32'h0000_0001) >> 1;
    wait_load = (step_total > cws_pkg::STEP_FIXED_CYC) ?
      (step_total - cws_pkg::STEP_FIXED_CYC) : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // store port
  always_comb begin
    store_bus.rd_slot = q.slot;
    store_bus.wr_slot = q.load_slot;
    store_bus.wr_data = merged;
    store_bus.wr_lo = take & avs_write_i & (idx == cws_pkg::IDX_TARGET);
    store_bus.wr_hi = take & avs_write_i & (idx == cws_pkg::IDX_VALUE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_q = q;
    next_q.we = 1'b0;
    // no bus answer is prepared while the bank read port serves a step
    next_q.ack = req & ~q.ack & (q.state != cws_pkg::S_WRITE);
    if (req & ~q.ack & (q.state != cws_pkg::S_WRITE)) begin
      next_q.rdata = {16'h0000, view};
    end

    case (q.state)
      cws_pkg::S_IDLE: begin
        next_q.go = 1'b0;
      end
      cws_pkg::S_LOAD: begin
        next_q.step = store_bus.rd_word;
        next_q.now_slot = q.slot;
        next_q.state = cws_pkg::S_WRITE;
      end
      cws_pkg::S_WRITE: begin
        next_q.we = 1'b1;
        next_q.waddr = st_addr;
        next_q.wdata = (ctl_rdata_i & ~field_mask) | field_bits;
        next_q.wait_cnt = wait_load[26:0];
        next_q.state = cws_pkg::S_WAIT;
      end
      cws_pkg::S_WAIT: begin
        if (q.wait_cnt != 27'h000_0000) begin
          next_q.wait_cnt = q.wait_cnt - 27'h000_0001;
        end else if (st_last) begin
          next_q.state = cws_pkg::S_IDLE;
          next_q.go = 1'b0;
        end else begin
          next_q.slot = q.slot + 6'h01;
          next_q.state = cws_pkg::S_LOAD;
        end
      end
      default: begin
        next_q.state = cws_pkg::S_IDLE;
      end
    endcase

    // host writes come last so a cancel overrides the step in flight
    if (take & avs_write_i) begin
      case (idx)
        cws_pkg::IDX_LOAD: begin
          next_q.load_slot = merged[cws_pkg::LOAD_SLOT_LSB +: 5];
        end
        cws_pkg::IDX_TARGET: begin
          next_q.word_tgt = merged;
        end
        cws_pkg::IDX_VALUE: begin
          next_q.word_val = merged;
        end
        cws_pkg::IDX_LAUNCH: begin
          next_q.first_slot = merged[cws_pkg::LAUNCH_FIRST_LSB +: 6];
          if (merged[cws_pkg::LAUNCH_CANCEL_BIT]) begin
            next_q.state = cws_pkg::S_IDLE;
            next_q.go = 1'b0;
            next_q.we = 1'b0;
            // a dropped step write must not move the bank outputs either
            next_q.waddr = q.waddr;
            next_q.wdata = q.wdata;
          end else if (merged[cws_pkg::LAUNCH_GO_BIT] & ~running) begin
            next_q.slot = merged[cws_pkg::LAUNCH_FIRST_LSB +: 6];
            next_q.go = 1'b1;
            next_q.state = cws_pkg::S_LOAD;
          end
        end
        cws_pkg::IDX_STATUS: begin
          next_q.rdata = q.rdata;
        end
        default: begin
          if (~running) begin
            next_q.we = 1'b1;
            next_q.waddr = idx;
            next_q.wdata = merged;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= cws_pkg::SEQ_RESET;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest_o = req & ~q.ack;
  assign avs_readdata_o = q.rdata;
  assign ctl_raddr_o = (q.state == cws_pkg::S_WRITE) ? st_addr : idx;
  assign ctl_we_o = q.we;
  assign ctl_waddr_o = q.waddr;
  assign ctl_wdata_o = q.wdata;

endmodule // cws_sequencer

`default_nettype wire

// >>> common/cws_pkg.sv
// constants, field layout and state types of the control write sequencer
// assumes: one 25 MHz clock, registers reached as 32-bit words over avalon-mm
`default_nettype none

package cws_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_LOAD = 8'h6C;
  localparam logic [7:0] IDX_TARGET = 8'h6D;
  localparam logic [7:0] IDX_VALUE = 8'h6E;
  localparam logic [7:0] IDX_LAUNCH = 8'h6F;
  localparam logic [7:0] IDX_STATUS = 8'h70;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside the 16-bit registers
  localparam int unsigned LOAD_SLOT_LSB = 0;
  localparam int unsigned TGT_WIDTH_LSB = 12;
  localparam int unsigned TGT_START_LSB = 8;
  localparam int unsigned TGT_ADDR_LSB = 0;
  localparam int unsigned VAL_LAST_BIT = 14;
  localparam int unsigned VAL_WAIT_LSB = 8;
  localparam int unsigned VAL_DATA_LSB = 0;
  localparam int unsigned LAUNCH_CANCEL_BIT = 9;
  localparam int unsigned LAUNCH_GO_BIT = 8;
  localparam int unsigned LAUNCH_FIRST_LSB = 0;
  localparam int unsigned STATUS_NOW_LSB = 4;
  localparam int unsigned STATUS_RUN_BIT = 0;
  // a stored step is {value/timing word, target word}
  localparam int unsigned STEP_HI_BASE = 16;

  ////////////////////////////////////////////////////////////////////////////
  // slot map and fixed slot contents
  localparam logic [5:0] RAM_SLOTS = 6'h20;
  // every fixed slot, and every reserved one, is a last step writing 0 to bit 0 of reg ff
  localparam logic [31:0] ROM_STEP = 32'h4000_00FF;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned STEP_UNIT_NS = 62500;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // unit is 1562.5 cycles, so keep twice it to stay integral
  localparam int unsigned STEP_UNIT_X2_CYC = (2 * STEP_UNIT_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam logic [31:0] STEP_FIXED_CYC = 32'h0000_0003;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_WRITE, S_WAIT} cws_state_t;

  typedef struct packed {
    cws_state_t state;
    logic [5:0] slot;
    logic [5:0] now_slot;
    logic go;
    logic [4:0] load_slot;
    logic [5:0] first_slot;
    logic [15:0] word_tgt;
    logic [15:0] word_val;
    logic [31:0] step;
    logic [26:0] wait_cnt;
    logic ack;
    logic [31:0] rdata;
    logic we;
    logic [7:0] waddr;
    logic [15:0] wdata;
  } cws_seq_t;

  localparam cws_seq_t SEQ_RESET = '{state: S_IDLE, default: '0};

  typedef struct packed {
    logic [31:0][31:0] ram;
  } cws_ram_t;

  localparam cws_ram_t RAM_RESET = '{default: '0};

endpackage

`default_nettype wire

// >>> common/cws_store_if.sv
// link between the sequencer and its step store
// assumes: both ends on the same clock
`default_nettype none

interface cws_store_if;
  logic wr_lo;
  logic wr_hi;
  logic [4:0] wr_slot;
  logic [15:0] wr_data;
  logic [5:0] rd_slot;
  logic [31:0] rd_word;

  modport ctrl (output wr_lo, output wr_hi, output wr_slot, output wr_data,
                output rd_slot, input rd_word);
  modport store (input wr_lo, input wr_hi, input wr_slot, input wr_data,
                 input rd_slot, output rd_word);
endinterface

`default_nettype wire

// >>> hdl/cws_step_store.sv
// step store: 32 writable slots plus fixed slots, read combinationally
// assumes: writes come from the sequencer on the same clock
`default_nettype none

module cws_step_store (
  input wire logic ref_clk_i, // 25 MHz clock
  input wire logic rst_n_i, // synchronous reset, active low
  cws_store_if.store bus // write and read port
);

  cws_pkg::cws_ram_t q;
  cws_pkg::cws_ram_t next_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    if (bus.wr_lo) begin
      next_q.ram[bus.wr_slot][15:0] = bus.wr_data;
    end
    if (bus.wr_hi) begin
      next_q.ram[bus.wr_slot][31:16] = bus.wr_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= cws_pkg::RAM_RESET;
    end else begin
      q <= next_q;
    end
  end

  // fixed and reserved slots end a sequence at once rather than run wild
  assign bus.rd_word = (bus.rd_slot < cws_pkg::RAM_SLOTS) ? q.ram[bus.rd_slot[4:0]] :
    cws_pkg::ROM_STEP;

endmodule // cws_step_store

`default_nettype wire

// >>> dv/cws_monitor.sv
// assertions on the sequencer's bus and control-bank ports
// assumes: bound to cws_sequencer, one clock, synchronous reset
`default_nettype none
module cws_monitor (
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic [9:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read
  input wire logic avs_write_i, // write
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [31:0] avs_readdata_o, // read data
  input wire logic avs_waitrequest_o, // stall
  input wire logic [7:0] ctl_raddr_o, // bank read address
  input wire logic ctl_we_o, // bank write strobe
  input wire logic [7:0] ctl_waddr_o, // bank write address
  input wire logic [15:0] ctl_wdata_o // bank write data
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic req;
  logic acc;
  assign req = avs_read_i | avs_write_i;
  assign acc = req & ~avs_waitrequest_o;
  ////////////////////////////////////////////////////////////
  property p_ack_bound;
    req && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("bus answer late");
  property p_ack_once;
    acc |=> !acc;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("double acknowledge");
  property p_rd_upper;
    acc && avs_read_i |-> avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read data set");
  property p_we_pulse;
    ctl_we_o |=> !ctl_we_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("bank strobe too long");
  property p_waddr_src;
    ctl_we_o |-> ctl_waddr_o == $past(ctl_raddr_o);
  endproperty
  a_waddr_src: assert property (p_waddr_src) else $error("bank write address");
  property p_hold_out;
    !ctl_we_o |-> $stable(ctl_waddr_o) && $stable(ctl_wdata_o);
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("bank outputs moved");
  property p_cancel;
    acc && avs_write_i && avs_address_i[9:2] == 8'h6F && avs_writedata_i[9] |=> !ctl_we_o;
  endproperty
  a_cancel: assert property (p_cancel) else $error("write after cancel");
  property p_cancel_rd;
    acc && avs_read_i && avs_address_i[9:2] == 8'h6F |-> !avs_readdata_o[9];
  endproperty
  a_cancel_rd: assert property (p_cancel_rd) else $error("cancel reads one");
  property p_status_rsv;
    acc && avs_read_i && avs_address_i[9:2] == 8'h70 |->
      avs_readdata_o[15:10] == 6'h00 && avs_readdata_o[3:1] == 3'h0;
  endproperty
  a_status_rsv: assert property (p_status_rsv) else $error("status spare bits");
  c_go: cover property (acc && avs_write_i && avs_writedata_i[8]);
  c_cancel: cover property (acc && avs_write_i && avs_writedata_i[9]);
  c_we: cover property (ctl_we_o);
endmodule // cws_monitor
`default_nettype wire

// >>> dv/cws_ctl_bank.sv
// control register bank standing behind the sequencer's ctl port
// assumes: combinational read, write at the clock edge while strobe high
`default_nettype none
module cws_ctl_bank (
  input wire logic ref_clk_i, // clock
  input wire logic [7:0] raddr_i, // read address
  output logic [15:0] rdata_o, // read data, same cycle
  input wire logic we_i, // write strobe
  input wire logic [7:0] waddr_i, // write address
  input wire logic [15:0] wdata_i // write data
);
  logic [15:0] mem [256];
  // no documented reset value, so a pattern that is neither all zero nor all one
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h5A5A;
  assign rdata_o = mem[raddr_i];
  always @(posedge ref_clk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule // cws_ctl_bank
`default_nettype wire

// >>> dv/test_control_write_sequencer.sv
// directed bench: host over avalon-mm, bank model on the ctl port
// assumes: step unit shortened to 4 half-units, so a step lasts (4*(2^D+8)+1)/2 cycles
`default_nettype none
module test_control_write_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [9:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [3:0] be = 4'h3;
  logic [31:0] rdat;
  logic [31:0] got;
  logic wreq;
  logic cwe;
  logic [7:0] craddr;
  logic [7:0] cwaddr;
  logic [15:0] crdata;
  logic [15:0] cwdata;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int pulses = 0;
  int last_we = 0;
  int gap = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  cws_sequencer #(.STEP_UNIT_X2_CYC(4)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .ctl_raddr_o(craddr),
    .ctl_rdata_i(crdata), .ctl_we_o(cwe), .ctl_waddr_o(cwaddr), .ctl_wdata_o(cwdata));
  cws_ctl_bank bank (.ref_clk_i(ref_clk_i), .raddr_i(craddr), .rdata_o(crdata),
    .we_i(cwe), .waddr_i(cwaddr), .wdata_i(cwdata));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cwe) begin
      pulses <= pulses + 1;
      gap <= cyc - last_we;
      last_we <= cyc;
    end
    if (cyc == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // called just after a rising edge; returns one edge after the answer
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    rd <= ~w;
    wr <= w;
    @(posedge ref_clk_i);
    while (wreq) @(posedge ref_clk_i);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic slot(input logic [4:0] n, input logic [15:0] t, input logic [15:0] v);
    bus(1'b1, 8'h6C, {11'h000, n});
    bus(1'b1, 8'h6D, t);
    bus(1'b1, 8'h6E, v);
  endtask
  task automatic wait_idle();
    got = 32'h1;
    while (got[0] !== 1'b0) bus(1'b0, 8'h70, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_steps();
    bank.mem[8'h21] = 16'hFFFF;
    bank.mem[8'h22] = 16'h1234;
    bank.mem[8'h30] = 16'h0F0F;
    // upper value bits set on purpose: the width must mask them
    slot(5'h00, 16'h3421, 16'h01FB);
    slot(5'h01, 16'h7C22, 16'h40A5);
    bus(1'b0, 8'h6D, 16'h0000); chk("target word", got, 32'h0000_7C22);
    bus(1'b0, 8'h6E, 16'h0000); chk("value word", got, 32'h0000_40A5);
    bus(1'b0, 8'h55, 16'h0000); chk("bank read", got, 32'h0000_5A5A);
    bus(1'b1, 8'h6F, 16'h0100);
    bus(1'b0, 8'h70, 16'h0000); chk("busy", got[0], 32'h1);
    bus(1'b1, 8'h30, 16'h0000);
    wait_idle();
    chk("refused write", bank.mem[8'h30], 32'h0F0F);
    chk("narrow step", bank.mem[8'h21], 32'hFFBF);
    chk("wide step", bank.mem[8'h22], 32'h5234);
    chk("step count", pulses, 2);
    chk("step period", gap, 20);
    bus(1'b0, 8'h6F, 16'h0000); chk("go cleared", got[8], 32'h0);
    bus(1'b0, 8'h70, 16'h0000); chk("now slot", got[9:4], 32'h1);
    bus(1'b1, 8'h30, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
    chk("idle write", bank.mem[8'h30], 32'h0000);
  endtask
  task automatic s_cancel();
    int p0;
    slot(5'h02, 16'h0040, 16'h0400);
    p0 = pulses;
    bus(1'b1, 8'h6F, 16'h0102);
    repeat (8) @(posedge ref_clk_i);
    bus(1'b1, 8'h6F, 16'h0200);
    bus(1'b0, 8'h70, 16'h0000); chk("cancel idle", got[0], 32'h0);
    repeat (120) @(posedge ref_clk_i);
    chk("steps after cancel", pulses - p0, 1);
  endtask
  task automatic s_fixed();
    bank.mem[8'hFF] = 16'hFFFF;
    bus(1'b1, 8'h6F, 16'h0120);
    wait_idle();
    chk("fixed slot step", bank.mem[8'hFF], 32'hFFFE);
    bus(1'b0, 8'h70, 16'h0000); chk("fixed now slot", got[9:4], 32'h20);
  endtask
  // partial writes keep the other byte: the bank's for control indices, the shadow's otherwise
  task automatic s_lanes();
    be <= 4'h1;
    bus(1'b1, 8'h30, 16'hABCD);
    be <= 4'h2;
    bus(1'b1, 8'h6D, 16'h1234);
    be <= 4'h3;
    repeat (2) @(posedge ref_clk_i);
    chk("low lane write", bank.mem[8'h30], 32'h0000_00CD);
    bus(1'b0, 8'h6D, 16'h0000); chk("high lane write", got, 32'h0000_1240);
  endtask
  // second reset while idle: target shadow word and status must return to zero
  task automatic s_reset();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    bus(1'b0, 8'h6D, 16'h0000); chk("target after reset", got, 32'h0000_0000);
    bus(1'b0, 8'h70, 16'h0000); chk("status after reset", got, 32'h0000_0000);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    s_steps();
    s_cancel();
    s_fixed();
    s_lanes();
    s_reset();
    complete_run();
  end
endmodule // test_control_write_sequencer
bind cws_sequencer cws_monitor mon (.*);
`default_nettype wire
